/* rtl/urem_top.v */
/*
 Line status, modem status and spare byte of a serial port, with a receive
 buffer (register or FIFO) behind an APB slave. Assumes all inputs are
 synchronous to pclk and an APB master using setup and access phases.
*/
// Notes on behaviour
// - A spacing stop bit sets the framing flag, line status bit 3.
// - After a framing error the bad stop bit is resampled as a start bit.
// - Wrong parity for the chosen even or odd setting sets line status bit 2.
// - In FIFO mode errors travel with each character and show at the head.
// - Without FIFO a new character over an unread one sets overrun and overwrites.
// - In FIFO mode overrun only when full; the shifted character is dropped.
// - Reading line status clears framing, parity and overrun flags.
// - Character-available sets once a character enters the buffer or FIFO.
// - Character-available clears when all received data is read out or a control write switches FIFO mode.
// - Modem status bits 7 to 4 are inverted carrier, bell, ready, clear inputs.
// - In loopback those bits show aux two, aux one, terminal ready, send request.
// - Any carrier-detect change sets modem status bit 3.
// - Bell-signal input rising from low to high sets modem status bit 2.
// - Peer-ready and clear-to-send changes set modem status bits 1 and 0.
// - Any of modem status bits 3 to 0 set raises the modem interrupt.
// - An eight-bit read/write spare byte with no effect on operation.
// - Overrun, parity or framing raise the line interrupt when it is enabled.
`include "urem_map.vh"

module urem_top #(
	parameter CLKS_PER_BIT = `UREM_CLKS_PER_BIT,
	parameter DEPTH        = `UREM_FIFO_DEPTH,
	parameter AW           = `UREM_FIFO_AW
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        serial_rx_in,
	input  wire        carrier_detect_in_n,
	input  wire        bell_signal_in_n,
	input  wire        peer_ready_in_n,
	input  wire        send_clear_in_n,
	output reg         terminal_ready_out_n,
	output reg         send_request_out_n,
	output reg         aux_output_one_n,
	output reg         aux_output_two_n,
	output reg         line_status_irq,
	output reg         modem_status_irq
);

	localparam [AW:0] FULL_COUNT = DEPTH;

	// Register state.
	reg [`UREM_CTL_WIDTH-1:0]   rx_control;
	reg [`UREM_MCR_WIDTH-1:0]   modem_control_reg;
	reg [7:0]                   spare_byte;
	reg                         frame_flag;
	reg                         parity_flag;
	reg                         overrun_flag;
	reg                         data_ready;
	reg [3:0]                   peer_levels;
	reg [3:0]                   change_flags;

	// Receive buffer.
	reg [`UREM_ENT_WIDTH-1:0]   rx_mem [0:DEPTH-1];
	reg [AW-1:0]                rd_ptr;
	reg [AW-1:0]                wr_ptr;
	reg [AW:0]                  count;

	// Receiver outputs.
	wire                        char_valid;
	wire [7:0]                  char_data;
	wire                        char_frame_err;
	wire                        char_parity_err;

	wire fifo_mode = rx_control[`UREM_CTL_FIFO_MODE];

	// =====================================================================
	// Serial receiver
	urem_rx_shift #(
		.CLKS_PER_BIT (CLKS_PER_BIT)
	) u_rx (
		.pclk            (pclk),
		.presetn         (presetn),
		.serial_rx_in    (serial_rx_in),
		.parity_en       (rx_control[`UREM_CTL_PARITY_EN]),
		.even_parity     (rx_control[`UREM_CTL_EVEN_PARITY]),
		.char_valid      (char_valid),
		.char_data       (char_data),
		.char_frame_err  (char_frame_err),
		.char_parity_err (char_parity_err)
	);

	// =====================================================================
	// APB decode
	function idx_hit;
		input [7:0] addr;
		input [5:0] idx;
		begin
			idx_hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
		end
	endfunction

	// The transfer completes on the access edge where pready is high.
	wire xfer_done = psel & penable & pready;
	wire wr_done   = xfer_done & pwrite;
	wire rd_done   = xfer_done & ~pwrite & ~pslverr;
	wire rd_data   = rd_done & idx_hit(paddr, `UREM_IDX_RX_DATA);
	wire rd_line   = rd_done & idx_hit(paddr, `UREM_IDX_LINE_FLAGS);
	wire rd_peer   = rd_done & idx_hit(paddr, `UREM_IDX_PEER_FLAGS);
	wire wr_ctl    = wr_done & idx_hit(paddr, `UREM_IDX_RX_CONTROL);
	wire mode_flip = wr_ctl & (pwdata[`UREM_CTL_FIFO_MODE] != fifo_mode);

	// =====================================================================
	// Read mux, captured in the setup cycle so prdata comes from a flip-flop.
	reg [31:0] next_prdata;
	reg        next_pslverr;
	always @* begin
		next_prdata  = `UREM_RST_WORD;
		next_pslverr = 1'b0;
		if (idx_hit(paddr, `UREM_IDX_RX_DATA)) begin
			next_prdata[7:0] = (count != {(AW+1){1'b0}}) ? rx_mem[rd_ptr][7:0] : 8'h00;
		end else if (idx_hit(paddr, `UREM_IDX_RX_CONTROL)) begin
			next_prdata[`UREM_CTL_WIDTH-1:0] = rx_control;
		end else if (idx_hit(paddr, `UREM_IDX_MODEM_CTRL)) begin
			next_prdata[`UREM_MCR_WIDTH-1:0] = modem_control_reg;
		end else if (idx_hit(paddr, `UREM_IDX_LINE_FLAGS)) begin
			next_prdata[`UREM_LSR_FRAMING]    = frame_flag;
			next_prdata[`UREM_LSR_PARITY]     = parity_flag;
			next_prdata[`UREM_LSR_OVERRUN]    = overrun_flag;
			next_prdata[`UREM_LSR_DATA_READY] = data_ready;
		end else if (idx_hit(paddr, `UREM_IDX_PEER_FLAGS)) begin
			next_prdata[7:0] = {peer_levels, change_flags};
		end else if (idx_hit(paddr, `UREM_IDX_SPARE_BYTE)) begin
			next_prdata[7:0] = spare_byte;
		end else begin
			next_pslverr = 1'b1;
		end
	end

	// Zero-wait slave: pready rises for the access cycle of each transfer.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `UREM_RST_WORD;
		end else begin
			pready <= psel & ~penable;
			if (psel & ~penable) begin
				pslverr <= next_pslverr;
				prdata  <= pwrite ? `UREM_RST_WORD : next_prdata;
			end
		end
	end

	// =====================================================================
	// Control, modem control and spare byte writes.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_control           <= `UREM_RST_CTL;
			modem_control_reg    <= `UREM_RST_MCR;
			spare_byte           <= `UREM_RST_BYTE;
			terminal_ready_out_n <= 1'b1;
			send_request_out_n   <= 1'b1;
			aux_output_one_n     <= 1'b1;
			aux_output_two_n     <= 1'b1;
		end else begin
			if (wr_ctl) begin
				rx_control <= pwdata[`UREM_CTL_WIDTH-1:0];
			end
			if (wr_done & idx_hit(paddr, `UREM_IDX_MODEM_CTRL)) begin
				modem_control_reg    <= pwdata[`UREM_MCR_WIDTH-1:0];
				terminal_ready_out_n <= ~pwdata[`UREM_MCR_TERM_READY];
				send_request_out_n   <= ~pwdata[`UREM_MCR_SEND_REQ];
				aux_output_one_n     <= ~pwdata[`UREM_MCR_AUX_ONE];
				aux_output_two_n     <= ~pwdata[`UREM_MCR_AUX_TWO];
			end
			if (wr_done & idx_hit(paddr, `UREM_IDX_SPARE_BYTE)) begin
				spare_byte <= pwdata[7:0];
			end
		end
	end

	// =====================================================================
	// Receive buffer control. Without FIFO mode the head slot is the buffer.
	wire buf_empty = (count == {(AW+1){1'b0}});
	wire pop       = rd_data & ~buf_empty;
	wire buf_full  = fifo_mode ? (count == FULL_COUNT) : ~buf_empty;
	wire lost      = char_valid & buf_full & ~pop;
	wire push      = char_valid & (~lost | ~fifo_mode);
	wire [AW-1:0] rd_ptr_inc = rd_ptr + {{(AW-1){1'b0}}, 1'b1};

	reg [AW:0]                next_count;
	reg                       head_change;
	reg [`UREM_ENT_WIDTH-1:0] next_head;
	always @* begin
		next_count  = count;
		head_change = 1'b0;
		next_head   = {char_frame_err, char_parity_err, char_data};
		if (!fifo_mode) begin
			// A new character replaces whatever is held, except in the cycle of a FIFO mode switch.
			if (push) begin
				next_count  = {{AW{1'b0}}, 1'b1};
				head_change = 1'b1;
			end else if (pop) begin
				next_count = {(AW+1){1'b0}};
			end
		end else begin
			next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
			// The head moves when a pop uncovers an older entry.
			if (pop && count > {{(AW-1){1'b0}}, 2'b01}) begin
				head_change = 1'b1;
				next_head   = rx_mem[rd_ptr_inc];
			end else if (push && (buf_empty || (pop && count == {{AW{1'b0}}, 1'b1}))) begin
				head_change = 1'b1;
			end
		end
		if (mode_flip) begin
			next_count  = {(AW+1){1'b0}};
			head_change = 1'b0;
		end
	end

	// Buffer storage, pointers and occupancy.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr     <= {AW{1'b0}};
			wr_ptr     <= {AW{1'b0}};
			count      <= {(AW+1){1'b0}};
			data_ready <= 1'b0;
		end else begin
			count      <= next_count;
			data_ready <= (next_count != {(AW+1){1'b0}});
			if (mode_flip) begin
				rd_ptr <= {AW{1'b0}};
				wr_ptr <= {AW{1'b0}};
			end else if (fifo_mode) begin
				if (pop) begin
					rd_ptr <= rd_ptr_inc;
				end
				if (push) begin
					wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
				end
			end else begin
				wr_ptr <= rd_ptr;
			end
		end
	end

	// Entry writes carry the character's own error bits.
	always @(posedge pclk) begin
		if (push & ~mode_flip) begin
			rx_mem[fifo_mode ? wr_ptr : rd_ptr] <= {char_frame_err, char_parity_err, char_data};
		end
	end

	// =====================================================================
	// Line status flags. A set in the cycle of the clearing read wins; the read
	// clears only the bits it actually returned.
	wire clr_fe = rd_line & prdata[`UREM_LSR_FRAMING];
	wire clr_pe = rd_line & prdata[`UREM_LSR_PARITY];
	wire clr_oe = rd_line & prdata[`UREM_LSR_OVERRUN];
	wire set_fe = head_change & next_head[`UREM_ENT_FRAMING];
	wire set_pe = head_change & next_head[`UREM_ENT_PARITY];
	wire set_oe = char_valid & ~buf_empty & ~pop & ~mode_flip;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_flag      <= 1'b0;
			parity_flag     <= 1'b0;
			overrun_flag    <= 1'b0;
			line_status_irq <= 1'b0;
		end else begin
			frame_flag   <= (frame_flag & ~clr_fe) | set_fe;
			parity_flag  <= (parity_flag & ~clr_pe) | set_pe;
			overrun_flag <= (overrun_flag & ~clr_oe) | (set_oe & buf_full);
			line_status_irq <= rx_control[`UREM_CTL_LINE_INT_EN] &
				(((frame_flag & ~clr_fe) | set_fe) |
				 ((parity_flag & ~clr_pe) | set_pe) |
				 ((overrun_flag & ~clr_oe) | (set_oe & buf_full)));
		end
	end

	// =====================================================================
	// Modem status: levels, change flags and interrupt.
	wire       loopback = modem_control_reg[`UREM_MCR_LOOPBACK];
	wire [3:0] next_levels = loopback ?
		{modem_control_reg[`UREM_MCR_AUX_TWO], modem_control_reg[`UREM_MCR_AUX_ONE],
		 modem_control_reg[`UREM_MCR_TERM_READY], modem_control_reg[`UREM_MCR_SEND_REQ]} :
		~{carrier_detect_in_n, bell_signal_in_n, peer_ready_in_n, send_clear_in_n};

	// Bit 3 carrier change, bit 2 bell end, bit 1 peer ready change, bit 0 clear change.
	wire [3:0] change_set = {next_levels[3] ^ peer_levels[3],
		peer_levels[2] & ~next_levels[2],
		next_levels[1:0] ^ peer_levels[1:0]};
	wire [3:0] change_clr = {4{rd_peer}} & prdata[3:0];
	wire [3:0] next_change = (change_flags & ~change_clr) | change_set;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peer_levels      <= 4'h0;
			change_flags     <= 4'h0;
			modem_status_irq <= 1'b0;
		end else begin
			peer_levels      <= next_levels;
			change_flags     <= next_change;
			modem_status_irq <= |next_change;
		end
	end

endmodule

/* rtl/urem_map.vh */
/*
 Register indices, fields, resets and defaults of the status block.
 Assumes byte address = index * 4 on APB.
*/
`ifndef UREM_MAP_VH
`define UREM_MAP_VH

// =====================================================================
// Register indices (byte address is four times the index)
`define UREM_IDX_RX_DATA      6'h00
`define UREM_IDX_RX_CONTROL   6'h03
`define UREM_IDX_MODEM_CTRL   6'h04
`define UREM_IDX_LINE_FLAGS   6'h05
`define UREM_IDX_PEER_FLAGS   6'h06
`define UREM_IDX_SPARE_BYTE   6'h07

// =====================================================================
// Receive control fields
`define UREM_CTL_FIFO_MODE    0
`define UREM_CTL_PARITY_EN    1
`define UREM_CTL_EVEN_PARITY  2
`define UREM_CTL_LINE_INT_EN  3
`define UREM_CTL_WIDTH        5

// =====================================================================
// Modem control fields
`define UREM_MCR_TERM_READY   0
`define UREM_MCR_SEND_REQ     1
`define UREM_MCR_AUX_ONE      2
`define UREM_MCR_AUX_TWO      3
`define UREM_MCR_LOOPBACK     4
`define UREM_MCR_WIDTH        5

// =====================================================================
// Line status fields
`define UREM_LSR_DATA_READY   0
`define UREM_LSR_OVERRUN      1
`define UREM_LSR_PARITY       2
`define UREM_LSR_FRAMING      3

// =====================================================================
// FIFO entry layout
`define UREM_ENT_PARITY       8
`define UREM_ENT_FRAMING      9
`define UREM_ENT_WIDTH        10

// =====================================================================
// Reset values and defaults
`define UREM_RST_BYTE         8'h00
`define UREM_RST_CTL          5'h00
`define UREM_RST_MCR          5'h00
`define UREM_RST_WORD         32'h0000_0000
`define UREM_CLKS_PER_BIT     16
`define UREM_FIFO_DEPTH       16
`define UREM_FIFO_AW          4

`endif

/* rtl/urem_rx_shift.v */
/*
 Serial receive shifter: one start bit, eight data bits, optional parity, one stop bit.
 Assumes serial_rx_in is synchronous to pclk; bit time is CLKS_PER_BIT clocks.
*/
`include "urem_map.vh"

module urem_rx_shift #(
	parameter CLKS_PER_BIT = `UREM_CLKS_PER_BIT
) (
	input  wire       pclk,
	input  wire       presetn,
	input  wire       serial_rx_in,
	input  wire       parity_en,
	input  wire       even_parity,
	output reg        char_valid,
	output reg  [7:0] char_data,
	output reg        char_frame_err,
	output reg        char_parity_err
);

	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_START  = 3'h1;
	localparam [2:0] ST_DATA   = 3'h2;
	localparam [2:0] ST_PARITY = 3'h3;
	localparam [2:0] ST_STOP   = 3'h4;
	localparam [2:0] ST_RESYNC = 3'h5;
	localparam [15:0] FULL_BIT = CLKS_PER_BIT - 1;
	localparam [15:0] HALF_BIT = CLKS_PER_BIT / 2 - 1;
	localparam [15:0] RESYNC_WAIT = CLKS_PER_BIT - 2;

	reg [2:0]  state;
	reg [15:0] bit_timer;
	reg [2:0]  bit_index;
	reg [7:0]  shift;
	reg        parity_bad;

	// =====================================================================
	// Receive sequencer; every sample is taken when the bit timer runs out.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state           <= ST_IDLE;
			bit_timer       <= 16'h0000;
			bit_index       <= 3'h0;
			shift           <= 8'h00;
			parity_bad      <= 1'b0;
			char_valid      <= 1'b0;
			char_data       <= 8'h00;
			char_frame_err  <= 1'b0;
			char_parity_err <= 1'b0;
		end else begin
			char_valid <= 1'b0;
			if (bit_timer != 16'h0000) begin
				bit_timer <= bit_timer - 16'h0001;
			end else begin
				case (state)
					ST_IDLE: begin
						if (!serial_rx_in) begin
							state     <= ST_START;
							bit_timer <= HALF_BIT;
						end
					end
					ST_START: begin
						// A start bit that is gone at mid-bit was a glitch.
						state      <= serial_rx_in ? ST_IDLE : ST_DATA;
						bit_timer  <= FULL_BIT;
						bit_index  <= 3'h0;
						parity_bad <= 1'b0;
					end
					ST_DATA: begin
						shift     <= {serial_rx_in, shift[7:1]};
						bit_index <= bit_index + 3'h1;
						bit_timer <= FULL_BIT;
						if (bit_index == 3'h7) begin
							state <= parity_en ? ST_PARITY : ST_STOP;
						end
					end
					ST_PARITY: begin
						// Even parity wants an even count of ones over data and parity.
						parity_bad <= (^shift ^ serial_rx_in) ^ ~even_parity;
						state      <= ST_STOP;
						bit_timer  <= FULL_BIT;
					end
					ST_STOP: begin
						char_valid      <= 1'b1;
						char_data       <= shift;
						char_parity_err <= parity_bad;
						char_frame_err  <= ~serial_rx_in;
						// A spacing stop bit is taken as the next start bit.
						state           <= serial_rx_in ? ST_IDLE : ST_RESYNC;
					end
					ST_RESYNC: begin
						// Second sample of the assumed start bit, then data follows.
						state      <= serial_rx_in ? ST_IDLE : ST_DATA;
						bit_timer  <= RESYNC_WAIT;
						bit_index  <= 3'h0;
						parity_bad <= 1'b0;
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

endmodule

/* verif/urem_chk.sv */
/*
 Port assertions on status, spare byte and interrupts of urem_top.
 Assumes it is bound into urem_top and sees only its ports.
*/
module urem_chk #(
	parameter CLKS_PER_BIT = 16
) (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        serial_rx_in,
	input logic        carrier_detect_in_n,
	input logic        bell_signal_in_n,
	input logic        peer_ready_in_n,
	input logic        send_clear_in_n,
	input logic        terminal_ready_out_n,
	input logic        send_request_out_n,
	input logic        aux_output_one_n,
	input logic        aux_output_two_n,
	input logic        line_status_irq,
	input logic        modem_status_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========
	// Shadow state
	localparam int IDLE_MIN = 12 * CLKS_PER_BIT;
	wire logic       acc    = psel && penable && pready;
	wire logic       rd_lsr = acc && !pwrite && paddr == 8'h14;
	wire logic       rd_msr = acc && !pwrite && paddr == 8'h18;
	wire logic [7:0] pins   = {carrier_detect_in_n, bell_signal_in_n, peer_ready_in_n,
		send_clear_in_n, terminal_ready_out_n, send_request_out_n, aux_output_one_n,
		aux_output_two_n};
	logic [7:0] spare_q;
	logic [7:0] pins_q;
	logic       loop_q;
	logic       en_q;
	logic       ready_q;
	int         idle_cnt;
	int         still_cnt;
	// Shadows writes and counts quiet cycles.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spare_q   <= 8'h00;
			pins_q    <= 8'hff;
			loop_q    <= 1'b0;
			en_q      <= 1'b0;
			ready_q   <= 1'b0;
			idle_cnt  <= 0;
			still_cnt <= 0;
		end else begin
			pins_q    <= pins;
			idle_cnt  <= !serial_rx_in ? 0 : (idle_cnt < IDLE_MIN ? idle_cnt + 1 : idle_cnt);
			still_cnt <= pins != pins_q ? 0 : (still_cnt < 8 ? still_cnt + 1 : still_cnt);
			if (acc && pwrite && paddr == 8'h1c) spare_q <= pwdata[7:0];
			if (acc && pwrite && paddr == 8'h10) loop_q <= pwdata[4];
			if (acc && pwrite && paddr == 8'h0c) en_q <= pwdata[3];
			if (rd_lsr && prdata[0]) ready_q <= 1'b1;
			if (acc && (paddr == 8'h00 || paddr == 8'h0c)) ready_q <= 1'b0;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// Assertions
	chk_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one cycle");
	chk_levels_direct: assert property (rd_msr && !loop_q && !$past(loop_q, 2) &&
		still_cnt >= 3 |-> prdata[7:4] == ~pins[7:4]) else $error("modem levels wrong");
	chk_levels_loop: assert property (rd_msr && loop_q && $past(loop_q, 2) &&
		still_cnt >= 3 |-> prdata[7:4] == ~{pins[0], pins[1], pins[3], pins[2]})
		else $error("loopback levels wrong");
	chk_modem_irq: assert property (rd_msr && prdata[3:0] != 4'h0 |-> modem_status_irq)
		else $error("modem irq low");
	chk_msr_clear: assert property (rd_msr && still_cnt >= 3 && pins == pins_q
		|=> !modem_status_irq) else $error("change flags kept");
	chk_line_irq: assert property (rd_lsr && prdata[3:1] != 3'h0 && en_q &&
		$past(en_q, 2) |-> line_status_irq) else $error("line irq low");
	chk_lsr_clear: assert property (rd_lsr && idle_cnt >= IDLE_MIN |-> ##2 !line_status_irq)
		else $error("errors kept");
	chk_ready_kept: assert property (rd_lsr && ready_q |-> prdata[0])
		else $error("data ready lost");
	chk_spare_value: assert property (acc && !pwrite && paddr == 8'h1c
		|-> prdata == {24'h000000, spare_q}) else $error("spare byte wrong");
	chk_reset_quiet: assert property ($rose(presetn)
		|-> !line_status_irq && !modem_status_irq) else $error("irq high after reset");
	cov_msr_change: cover property (rd_msr && prdata[3:0] != 4'h0);
	cov_overrun: cover property (rd_lsr && prdata[1]);
	cov_framing: cover property (rd_lsr && prdata[3]);
endmodule

bind urem_top urem_chk #(.CLKS_PER_BIT(CLKS_PER_BIT)) urem_chk_inst (.*);

/* verif/urem_peer.sv */
/*
 Serial sender and modem handshake lines facing urem_top.
 Assumes the bench calls its tasks.
*/
module urem_peer #(
	parameter CLKS_PER_BIT = 16
) (
	input  wire logic pclk,
	output logic      serial_rx_in,
	output logic      carrier_detect_in_n,
	output logic      bell_signal_in_n,
	output logic      peer_ready_in_n,
	output logic      send_clear_in_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Line idles high and all handshake inputs start inactive.
	initial begin
		serial_rx_in = 1'b1;
		{carrier_detect_in_n, bell_signal_in_n, peer_ready_in_n, send_clear_in_n} = 4'hf;
	end
	// Holds one level for a whole bit time.
	task automatic put_bit(input logic b);
		serial_rx_in <= b;
		repeat (CLKS_PER_BIT) @(posedge pclk);
	endtask
	// Sends a frame; a low stop bit may serve as the next start.
	task automatic send(input logic [7:0] d, input logic par_en, input logic even,
		input logic bad_par, input logic bad_stop, input logic no_start);
		@(posedge pclk);
		if (!no_start) put_bit(1'b0);
		for (int i = 0; i < 8; i++) put_bit(d[i]);
		if (par_en) put_bit(^d ^ !even ^ bad_par);
		put_bit(!bad_stop);
	endtask
	// Drives carrier, bell, ready and clear lines in that order.
	task automatic set_modem(input logic [3:0] v);
		@(posedge pclk);
		{carrier_detect_in_n, bell_signal_in_n, peer_ready_in_n, send_clear_in_n} <= v;
	endtask
endmodule

/* verif/urem_top_tb.sv */
/*
 Self-checking APB bench for urem_top with a serial peer.
 Assumes urem_peer and urem_chk are compiled with it.
*/
`include "urem_map.vh"

module urem_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int         CPB   = 4;
	localparam int         DEP   = 4;
	localparam int         IDLE  = 12 * CPB;
	localparam logic [7:0] A_DAT = {`UREM_IDX_RX_DATA, 2'b00};
	localparam logic [7:0] A_CTL = {`UREM_IDX_RX_CONTROL, 2'b00};
	localparam logic [7:0] A_MCR = {`UREM_IDX_MODEM_CTRL, 2'b00};
	localparam logic [7:0] A_LSR = {`UREM_IDX_LINE_FLAGS, 2'b00};
	localparam logic [7:0] A_MSR = {`UREM_IDX_PEER_FLAGS, 2'b00};
	localparam logic [7:0] A_SPR = {`UREM_IDX_SPARE_BYTE, 2'b00};
	logic        pclk, presetn, psel, penable, pwrite, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, rd;
	wire  [31:0] prdata;
	wire         pready, pslverr, serial_rx_in, carrier_detect_in_n, bell_signal_in_n;
	wire         peer_ready_in_n, send_clear_in_n, terminal_ready_out_n, send_request_out_n;
	wire         aux_output_one_n, aux_output_two_n, line_status_irq, modem_status_irq;
	int          bad_count = 0;
	int          samples_checked = 0;
	logic [3:0]  mod_in [6] = '{4'h7, 4'h7, 4'h3, 4'h7, 4'h4, 4'hf};
	logic [7:0]  mod_exp [6] = '{8'h88, 8'h80, 8'hc0, 8'h84, 8'hb3, 8'h0b};
	logic [7:0]  loop_exp [4] = '{8'h20, 8'h10, 8'h40, 8'h80};

	urem_top #(.CLKS_PER_BIT(CPB), .DEPTH(DEP), .AW(2)) urem_top_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_rx_in,
		.carrier_detect_in_n, .bell_signal_in_n, .peer_ready_in_n, .send_clear_in_n,
		.terminal_ready_out_n, .send_request_out_n, .aux_output_one_n, .aux_output_two_n,
		.line_status_irq, .modem_status_irq);
	urem_peer #(.CLKS_PER_BIT(CPB)) urem_peer_inst (.pclk, .serial_rx_in, .carrier_detect_in_n,
		.bell_signal_in_n, .peer_ready_in_n, .send_clear_in_n);

	// Free-running 20 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ==========
	// Tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One APB transfer; holds the request until pready is seen at a rising edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	// Flags are {parity on, even, bad parity, bad stop, no start}.
	task automatic tx(input logic [7:0] d, input logic [4:0] f, input bit idle);
		urem_peer_inst.send(d, f[4], f[3], f[2], f[1], f[0]);
		if (idle) repeat (IDLE) @(posedge pclk);
	endtask
	task automatic results();
		$display("Checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Cuts a hang short well after the sequence should have ended.
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		results();
	end
	// ==========
	// Test sequence
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rc("line", A_LSR, 32'h0);
		rc("peer", A_MSR, 32'h0);
		rc("spare", A_SPR, 32'h0);
		$display("Test reset done");
		// Spare byte round trips, leaves status alone; unmapped reads are refused.
		foreach (loop_exp[i]) begin
			wr_spare: bus(1'b1, A_SPR, {24'h0, ~loop_exp[i]});
			rc("spare", A_SPR, {24'h0, ~loop_exp[i]});
		end
		rc("line", A_LSR, 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		$display("Test spare done");
		// Without FIFO a second character overwrites the unread first.
		tx(8'h3c, 5'h00, 1'b0);
		tx(8'hc3, 5'h00, 1'b1);
		rc("line", A_LSR, 32'h3);
		rc("line", A_LSR, 32'h1);
		rc("data", A_DAT, 32'hc3);
		rc("line", A_LSR, 32'h0);
		$display("Test buffer overrun done");
		// A full FIFO drops the extra character.
		bus(1'b1, A_CTL, 32'h1);
		for (int i = 0; i <= DEP; i++) tx(8'h10 + i[7:0], 5'h00, i == DEP);
		rc("line", A_LSR, 32'h3);
		for (int i = 0; i < DEP; i++) rc("data", A_DAT, 32'h10 + i);
		rc("line", A_LSR, 32'h0);
		$display("Test fifo overrun done");
		// Framing error behind a good head; the bad stop starts the next character.
		tx(8'h77, 5'h00, 1'b0);
		tx(8'h5a, 5'h02, 1'b0);
		tx(8'ha6, 5'h01, 1'b1);
		rc("line", A_LSR, 32'h1);
		rc("data", A_DAT, 32'h77);
		rc("line", A_LSR, 32'h9);
		rc("line", A_LSR, 32'h1);
		rc("data", A_DAT, 32'h5a);
		rc("data", A_DAT, 32'ha6);
		rc("line", A_LSR, 32'h0);
		$display("Test framing done");
		// Parity checked in both senses with the line interrupt enabled.
		for (int e = 0; e < 2; e++) begin
			bus(1'b1, A_CTL, {28'h0, 1'b1, e[0], 2'b11});
			tx(8'h6b, {1'b1, e[0], 3'b000}, 1'b1);
			rc("line", A_LSR, 32'h1);
			rc("data", A_DAT, 32'h6b);
			tx(8'h6b, {1'b1, e[0], 3'b100}, 1'b1);
			chk("line irq", {31'h0, line_status_irq}, 32'h1);
			rc("line", A_LSR, 32'h5);
			rc("data", A_DAT, 32'h6b);
		end
		chk("line irq", {31'h0, line_status_irq}, 32'h0);
		$display("Test parity done");
		// Handshake levels and change flags, each read clearing what it returned.
		foreach (mod_in[i]) begin
			urem_peer_inst.set_modem(mod_in[i]);
			repeat (3) @(posedge pclk);
			chk("modem irq", {31'h0, modem_status_irq}, {31'h0, mod_exp[i][3:0] != 4'h0});
			rc("peer", A_MSR, {24'h0, mod_exp[i]});
		end
		$display("Test modem done");
		// Loopback maps each control output onto one status level.
		foreach (loop_exp[i]) begin
			bus(1'b1, A_MCR, 32'h10 | (32'h1 << i));
			repeat (3) @(posedge pclk);
			chk("modem pins", {28'h0, aux_output_two_n, aux_output_one_n, send_request_out_n,
				terminal_ready_out_n}, {28'h0, ~(4'h1 << i)});
			bus(1'b0, A_MSR, 32'h0);
			chk("loop levels", rd & 32'hf0, {24'h0, loop_exp[i]});
		end
		bus(1'b1, A_MCR, 32'h0);
		repeat (3) @(posedge pclk);
		bus(1'b0, A_MSR, 32'h0);
		rc("peer", A_MSR, 32'h0);
		$display("Test loopback done");
		results();
	end
endmodule
